// *** rtl/rx_regs_map.svh ***
// offsets, field positions, reset values and constants of the receive mode and self-test registers
`ifndef RX_REGS_MAP_SVH
`define RX_REGS_MAP_SVH

`define ADDR_W 12
`define RMS_IDX 8'h23
`define ST_IDX 8'h24
`define RMS_ADDR ({2'b00, `RMS_IDX, 2'b00})
`define ST_ADDR ({2'b00, `ST_IDX, 2'b00})

`define RMS_DIV_BIT 6
`define RMS_AUTO_BIT 5
`define RMS_FAST_BIT 4
`define RMS_COAX_BIT 3
`define RMS_RPTR_BIT 2

`define ST_MODE 7:6
`define ST_FREQ 5:4
`define ST_PIN_BIT 3
`define ST_SRC 2:1
`define ST_CFG 2:0
`define ST_EN_BIT 0

`define AUTO_RST 1'b1
`define ST_RST 8'h08

`define STRAP_FAST_BIT 0
`define STRAP_COAX_BIT 1
`define STRAP_RPTR_BIT 2

`define REMOTE_CLKSRC_OFS 8'h14

`define OSC_50 6'h32
`define OSC_25 6'h19
`define OSC_10 6'h0A

`endif

// *** rtl/rx_regs_pkg.sv ***
// types shared by the receive mode and self-test register block
package rx_regs_pkg;
	typedef enum logic [1:0] {RATE_DIV4, RATE_DIV2, RATE_FAST} return_rate_t;
	typedef enum logic [1:0] {SEL_NONE, SEL_RMS, SEL_ST} reg_sel_t;
	typedef enum logic [1:0] {XF_IDLE, XF_REQ} xfer_state_t;
endpackage

// *** rtl/rx_cfg_if.sv ***
// configuration and result signals between the register block and its helpers
`timescale 1ns/1ns
interface rx_cfg_if;
	import rx_regs_pkg::*;
	logic fast_rate_en;
	logic div_sel;
	logic [7:0] st_ctrl;
	return_rate_t rate_mode;
	logic st_active;
	logic st_bit;
	logic rw_req;
	logic [7:0] rw_addr;
	logic [1:0] rw_data;
	modport regs (output fast_rate_en, div_sel, st_ctrl, input rate_mode, st_active, st_bit, rw_req, rw_addr, rw_data);
	modport rate (input fast_rate_en, div_sel, output rate_mode);
	modport selftest (input st_ctrl, output st_active, st_bit, rw_req, rw_addr, rw_data);
endinterface

// *** rtl/return_rate_sel.sv ***
// return channel rate selection
`timescale 1ns/1ns
`include "rx_regs_map.svh"
module return_rate_sel
	import rx_regs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	rx_cfg_if.rate cif
);
	return_rate_t rate_ff;
	return_rate_t nxt_rate;

	always_comb
	begin
		nxt_rate = RATE_DIV4;
		if (cif.fast_rate_en)
			nxt_rate = RATE_FAST; // [RULE2]
		else if (cif.div_sel)
			nxt_rate = RATE_DIV2; // [RULE1]
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			rate_ff <= RATE_DIV4;
		else
			rate_ff <= nxt_rate;
	end

	assign cif.rate_mode = rate_ff;
endmodule

// *** rtl/selftest_ctrl.sv ***
// self-test enable, pattern output and remote clock source transfer
`timescale 1ns/1ns
`include "rx_regs_map.svh"
module selftest_ctrl
	import rx_regs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [2:0] pin_cfg,
	input wire logic st_data,
	input wire logic rw_ack,
	rx_cfg_if.selftest cif
);
	logic [2:0] eff_cfg;
	logic en_q_ff, nxt_en_q;
	logic tx_ff, nxt_tx;
	xfer_state_t xf_ff, nxt_xf;
	logic [7:0] addr_ff, nxt_addr;
	logic [1:0] data_ff, nxt_data;

	always_comb
	begin
		// pin or register bits 2:0 configure the test
		eff_cfg = cif.st_ctrl[`ST_PIN_BIT] ? pin_cfg : cif.st_ctrl[`ST_CFG]; // [RULE10]
		nxt_en_q = eff_cfg[`ST_EN_BIT]; // [RULE12]
		nxt_tx = 1'b0;
		if (eff_cfg[`ST_EN_BIT])
		begin
			if (cif.st_ctrl[7])
				nxt_tx = st_data; // [RULE8]
			else if (cif.st_ctrl[6])
				nxt_tx = ~tx_ff; // [RULE8]
		end
		nxt_xf = xf_ff;
		nxt_addr = addr_ff;
		nxt_data = data_ff;
		case (xf_ff)
			XF_IDLE:
			begin
				if (eff_cfg[`ST_EN_BIT] && !en_q_ff)
				begin
					nxt_xf = XF_REQ; // [RULE11]
					nxt_addr = `REMOTE_CLKSRC_OFS;
					nxt_data = eff_cfg[`ST_SRC];
				end
			end
			XF_REQ:
			begin
				if (rw_ack)
					nxt_xf = XF_IDLE;
			end
			default:
				nxt_xf = XF_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			en_q_ff <= 1'b0;
			tx_ff <= 1'b0;
			xf_ff <= XF_IDLE;
			addr_ff <= 8'h00;
			data_ff <= 2'h0;
		end
		else
		begin
			en_q_ff <= nxt_en_q;
			tx_ff <= nxt_tx;
			xf_ff <= nxt_xf;
			addr_ff <= nxt_addr;
			data_ff <= nxt_data;
		end
	end

	assign cif.st_active = en_q_ff;
	assign cif.st_bit = tx_ff;
	assign cif.rw_req = (xf_ff == XF_REQ);
	assign cif.rw_addr = addr_ff;
	assign cif.rw_data = data_ff;
endmodule

// *** rtl/rx_mode_and_selftest_regs.sv ***
// receive mode and self-test register bank on an apb slave
// Overview of operation
// [RULE1] with the fast bit clear, the divider select bit picks divide-by-4 at 0 and divide-by-2 at 1.
// [RULE2] the fast bit runs the return channel at 20 Mbps whatever the divider select says.
// [RULE3] the remote side sets its serializer to auto-acknowledge before a rate change over the control channel; this block sends no such write.
// [RULE4] the automatic audio bit resets to 1 and while set audio mode follows the received aux codes.
// [RULE5] the fast bit is loaded from the mode strap when reset ends.
// [RULE6] the cable bit means twisted pair at 0 and coax at 1 and is loaded from the mode strap.
// [RULE7] the repeater bit is read only and shows the strapped repeater setting.
// [RULE8] output mode bits 7-6 give no toggling at 00, alternating toggling at 01, self-test data at 1x.
// [RULE9] with automatic clock enable, bits 5-4 select 50, 25 or 10 MHz, 11 reserved.
// [RULE10] the config source bit resets to 1 for the pin, and at 0 bits 2:0 configure the test.
// [RULE11] when self-test starts, the clock source field is sent to remote offset 0x14.
// [RULE12] bit 0 starts self-test at 1, stops it at 0, and resets to 0.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`include "rx_regs_map.svh"
module rx_mode_and_selftest_regs
	import rx_regs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] mode_strap_input,
	input wire logic auto_clock_en,
	input wire logic aux_code_valid,
	input wire logic [1:0] aux_audio_code,
	input wire logic [2:0] selftest_pin_cfg,
	input wire logic selftest_data,
	input wire logic remote_wr_ack,
	output logic [1:0] return_rate_mode,
	output logic audio_mode_auto,
	output logic [1:0] audio_mode,
	output logic coax_mode,
	output logic repeater_mode,
	output logic [1:0] osc_rx_clock_freq,
	output logic [5:0] osc_rx_clock_mhz,
	output logic selftest_active,
	output logic selftest_tx_bit,
	output logic remote_wr_req,
	output logic [7:0] remote_wr_addr,
	output logic [1:0] remote_wr_data
);
	rx_cfg_if cif ();

	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic [31:0] prdata_ff, nxt_prdata;
	logic div_sel_ff, nxt_div_sel;
	logic audio_auto_ff, nxt_audio_auto;
	logic fast_ff, nxt_fast;
	logic coax_ff, nxt_coax;
	logic rptr_ff, nxt_rptr;
	logic [7:0] st_ctrl_ff, nxt_st_ctrl;
	logic strap_pend_ff, nxt_strap_pend;
	logic [1:0] audio_mode_ff, nxt_audio_mode;
	logic [1:0] osc_sel_ff, nxt_osc_sel;
	logic [5:0] osc_mhz_ff, nxt_osc_mhz;
	logic acc;
	logic wr;
	logic strap_load;
	reg_sel_t sel;
	logic strap_fast, strap_coax, strap_rptr;

	function automatic reg_sel_t decode(input logic [`ADDR_W-1:0] a);
		reg_sel_t s;
		s = SEL_NONE;
		if (a == `RMS_ADDR)
			s = SEL_RMS;
		else if (a == `ST_ADDR)
			s = SEL_ST;
		return s;
	endfunction

	function automatic logic [5:0] osc_mhz(input logic [1:0] f);
		logic [5:0] m;
		case (f)
			2'h0: m = `OSC_50;
			2'h2: m = `OSC_10;
			default: m = `OSC_25;
		endcase
		return m;
	endfunction

	assign strap_fast = mode_strap_input[`STRAP_FAST_BIT];
	assign strap_coax = mode_strap_input[`STRAP_COAX_BIT];
	assign strap_rptr = mode_strap_input[`STRAP_RPTR_BIT];
	assign acc = psel && penable;
	assign sel = decode(paddr);
	assign wr = acc && pready_ff && pwrite && !pslverr_ff && pstrb[0];
	assign strap_load = strap_pend_ff && !rst;

	always_comb
	begin
		nxt_pready = acc && !pready_ff;
		nxt_pslverr = pslverr_ff;
		nxt_prdata = prdata_ff;
		if (acc && !pready_ff)
		begin
			nxt_pslverr = (sel == SEL_NONE);
			nxt_prdata = 32'h0000_0000;
			if (!pwrite && sel == SEL_RMS)
				nxt_prdata[7:0] = {1'b0, div_sel_ff, audio_auto_ff, fast_ff, coax_ff, rptr_ff, 2'b00}; // [RULE7]
			else if (!pwrite && sel == SEL_ST)
				nxt_prdata[7:0] = st_ctrl_ff;
		end
		else if (!acc)
			nxt_pslverr = 1'b0;
	end

	always_comb
	begin
		nxt_div_sel = div_sel_ff;
		nxt_audio_auto = audio_auto_ff;
		nxt_fast = fast_ff;
		nxt_coax = coax_ff;
		nxt_rptr = rptr_ff;
		nxt_st_ctrl = st_ctrl_ff;
		nxt_strap_pend = 1'b0;
		if (wr && sel == SEL_RMS)
		begin
			nxt_div_sel = pwdata[`RMS_DIV_BIT]; // [RULE1]
			nxt_audio_auto = pwdata[`RMS_AUTO_BIT]; // [RULE4]
			nxt_fast = pwdata[`RMS_FAST_BIT]; // [RULE2]
			nxt_coax = pwdata[`RMS_COAX_BIT]; // [RULE6]
		end
		if (wr && sel == SEL_ST)
			nxt_st_ctrl = pwdata[7:0]; // [RULE12]
		if (strap_load)
		begin
			nxt_fast = strap_fast; // [RULE5]
			nxt_coax = strap_coax; // [RULE6]
			nxt_rptr = strap_rptr; // [RULE7]
		end
	end

	always_comb
	begin
		nxt_audio_mode = audio_mode_ff;
		if (audio_auto_ff && aux_code_valid)
			nxt_audio_mode = aux_audio_code; // [RULE4]
		nxt_osc_sel = st_ctrl_ff[`ST_FREQ];
		nxt_osc_mhz = 6'h00;
		if (auto_clock_en)
			nxt_osc_mhz = osc_mhz(st_ctrl_ff[`ST_FREQ]); // [RULE9]
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			div_sel_ff <= 1'b0;
			audio_auto_ff <= `AUTO_RST; // [RULE4]
			fast_ff <= 1'b0;
			coax_ff <= 1'b0;
			rptr_ff <= 1'b0;
			st_ctrl_ff <= `ST_RST; // [RULE10]
			strap_pend_ff <= 1'b1;
			audio_mode_ff <= 2'h0;
			osc_sel_ff <= 2'h0;
			osc_mhz_ff <= 6'h00;
		end
		else
		begin
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff <= nxt_prdata;
			div_sel_ff <= nxt_div_sel;
			audio_auto_ff <= nxt_audio_auto;
			fast_ff <= nxt_fast;
			coax_ff <= nxt_coax;
			rptr_ff <= nxt_rptr;
			st_ctrl_ff <= nxt_st_ctrl;
			strap_pend_ff <= nxt_strap_pend;
			audio_mode_ff <= nxt_audio_mode;
			osc_sel_ff <= nxt_osc_sel;
			osc_mhz_ff <= nxt_osc_mhz;
		end
	end

	assign cif.fast_rate_en = fast_ff;
	assign cif.div_sel = div_sel_ff;
	assign cif.st_ctrl = st_ctrl_ff;

	return_rate_sel u_rate (
		.sys_clk(sys_clk),
		.rst(rst),
		.cif(cif)
	);

	selftest_ctrl u_selftest (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_cfg(selftest_pin_cfg),
		.st_data(selftest_data),
		.rw_ack(remote_wr_ack),
		.cif(cif)
	);

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign return_rate_mode = cif.rate_mode;
	assign audio_mode_auto = audio_auto_ff;
	assign audio_mode = audio_mode_ff;
	assign coax_mode = coax_ff;
	assign repeater_mode = rptr_ff;
	assign osc_rx_clock_freq = osc_sel_ff;
	assign osc_rx_clock_mhz = osc_mhz_ff;
	assign selftest_active = cif.st_active;
	assign selftest_tx_bit = cif.st_bit;
	assign remote_wr_req = cif.rw_req;
	assign remote_wr_addr = cif.rw_addr;
	assign remote_wr_data = cif.rw_data;

	property p_rate_div;
		@(posedge sys_clk) disable iff (rst)
		!fast_ff |=> return_rate_mode == ($past(div_sel_ff) ? RATE_DIV2 : RATE_DIV4);
	endproperty
	a_rate_div: assert property (p_rate_div) else $error("divider rate wrong"); // [RULE1]

	property p_rate_fast;
		@(posedge sys_clk) disable iff (rst)
		fast_ff |=> return_rate_mode == RATE_FAST;
	endproperty
	a_rate_fast: assert property (p_rate_fast) else $error("fast rate not selected"); // [RULE2]

	property p_audio_follow;
		@(posedge sys_clk) disable iff (rst)
		(audio_auto_ff && aux_code_valid) |=> audio_mode == $past(aux_audio_code);
	endproperty
	a_audio_follow: assert property (p_audio_follow) else $error("audio mode did not follow aux code"); // [RULE4]

	property p_audio_reset;
		@(posedge sys_clk)
		rst |=> audio_mode_auto && st_ctrl_ff == `ST_RST;
	endproperty
	a_audio_reset: assert property (p_audio_reset) else $error("reset values wrong"); // [RULE4]

	property p_strap_fast;
		@(posedge sys_clk) disable iff (rst)
		strap_load |=> fast_ff == $past(strap_fast);
	endproperty
	a_strap_fast: assert property (p_strap_fast) else $error("fast bit not strapped"); // [RULE5]

	property p_strap_coax;
		@(posedge sys_clk) disable iff (rst)
		strap_load |=> coax_mode == $past(strap_coax);
	endproperty
	a_strap_coax: assert property (p_strap_coax) else $error("cable bit not strapped"); // [RULE6]

	property p_rptr_stable;
		@(posedge sys_clk) disable iff (rst)
		!strap_load |=> $stable(repeater_mode);
	endproperty
	a_rptr_stable: assert property (p_rptr_stable) else $error("repeater bit changed"); // [RULE7]

	property p_no_toggle;
		@(posedge sys_clk) disable iff (rst)
		st_ctrl_ff[`ST_MODE] == 2'b00 |=> !selftest_tx_bit;
	endproperty
	a_no_toggle: assert property (p_no_toggle) else $error("output toggled in mode 00"); // [RULE8]

	property p_osc_10;
		@(posedge sys_clk) disable iff (rst)
		(auto_clock_en && st_ctrl_ff[`ST_FREQ] == 2'b10) |=> osc_rx_clock_mhz == `OSC_10;
	endproperty
	a_osc_10: assert property (p_osc_10) else $error("oscillator clock not 10 MHz"); // [RULE9]

	property p_reg_cfg;
		@(posedge sys_clk) disable iff (rst)
		(!st_ctrl_ff[`ST_PIN_BIT] && st_ctrl_ff[`ST_EN_BIT]) |=> selftest_active;
	endproperty
	a_reg_cfg: assert property (p_reg_cfg) else $error("register config ignored"); // [RULE10]

	property p_remote_xfer;
		@(posedge sys_clk) disable iff (rst)
		$rose(selftest_active) |-> remote_wr_req && remote_wr_addr == `REMOTE_CLKSRC_OFS;
	endproperty
	a_remote_xfer: assert property (p_remote_xfer) else $error("clock source not sent"); // [RULE11]

	property p_start_bit;
		@(posedge sys_clk) disable iff (rst)
		(wr && sel == SEL_ST) |=> st_ctrl_ff[`ST_EN_BIT] == $past(pwdata[0]);
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("enable bit not written"); // [RULE12]

	property p_apb_wait;
		@(posedge sys_clk) disable iff (rst)
		(acc && !pready_ff) |=> pready ##1 !pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong");

	c_fast: cover property (@(posedge sys_clk) disable iff (rst) return_rate_mode == RATE_FAST);
	c_toggle: cover property (@(posedge sys_clk) disable iff (rst) selftest_tx_bit ##1 !selftest_tx_bit);
	c_xfer: cover property (@(posedge sys_clk) disable iff (rst) remote_wr_req && remote_wr_ack);
	c_err: cover property (@(posedge sys_clk) disable iff (rst) pready && pslverr);
endmodule

// *** bench/remote_ser_model.sv ***
// remote serializer model that answers clock source writes over the control channel
`timescale 1ns/1ns
module remote_ser_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic auto_ack,
	input wire logic [3:0] ack_delay,
	input wire logic wr_req,
	input wire logic [7:0] wr_addr,
	input wire logic [1:0] wr_data,
	output logic wr_ack,
	output logic [1:0] clk_src_ff
);
	logic [3:0] wait_ff;
	always_ff @(posedge sys_clk)
	begin
		if (rst || !wr_req || wr_ack)
		begin
			wait_ff <= 4'h0;
			wr_ack <= 1'b0;
		end
		else
		begin
			wait_ff <= wait_ff + 4'h1;
			wr_ack <= auto_ack || (wait_ff >= ack_delay);
		end
		if (rst)
			clk_src_ff <= 2'h0;
		else if (wr_req && wr_ack && wr_addr == 8'h14)
			clk_src_ff <= wr_data;
	end
endmodule

// *** bench/test_rx_mode_and_selftest_regs.sv ***
// testbench of the receive mode and self-test register bank
`timescale 1ns/1ns
`include "rx_regs_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("wrong value t=%0t got %0h exp %0h", $time, g, e); end end
module test_rx_mode_and_selftest_regs;
	logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0] strap, pin_cfg;
	logic auto_clock_en, aux_valid, st_data, ack, auto_ack, coax, rptr, st_act, tx, req, aud_auto, t0;
	logic [1:0] aux_code, rate, aud, freq, wdata, src;
	logic [5:0] mhz;
	logic [7:0] waddr;
	logic [3:0] strb;
	int err_total, checks;
	rx_mode_and_selftest_regs u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mode_strap_input(strap), .auto_clock_en(auto_clock_en), .aux_code_valid(aux_valid),
		.aux_audio_code(aux_code), .selftest_pin_cfg(pin_cfg), .selftest_data(st_data), .remote_wr_ack(ack),
		.return_rate_mode(rate), .audio_mode_auto(aud_auto), .audio_mode(aud), .coax_mode(coax),
		.repeater_mode(rptr), .osc_rx_clock_freq(freq), .osc_rx_clock_mhz(mhz), .selftest_active(st_act),
		.selftest_tx_bit(tx), .remote_wr_req(req), .remote_wr_addr(waddr), .remote_wr_data(wdata));
	remote_ser_model u_remote (.sys_clk(sys_clk), .rst(rst), .auto_ack(auto_ack), .ack_delay(4'h3),
		.wr_req(req), .wr_addr(waddr), .wr_data(wdata), .wr_ack(ack), .clk_src_ff(src));
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic w(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [7:0] er, input logic ee);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge sys_clk);
		end
		while (pready !== 1'b1);
		if (!wr)
			`CHK(prdata, {24'h000000, er})
		`CHK(pslverr, ee)
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
		`CHK(pready, 1'b0)
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic t_reset();
		apb(1'b0, `RMS_ADDR, 8'h00, 8'h34, 1'b0);
		apb(1'b0, `ST_ADDR, 8'h00, `ST_RST, 1'b0);
		`CHK(rate, 2'h2)
		`CHK(coax, 1'b0)
		`CHK(rptr, 1'b1)
		`CHK(aud_auto, 1'b1)
		`CHK(st_act, 1'b0)
		$display("reset test done");
	endtask
	task automatic t_rate();
		apb(1'b1, `RMS_ADDR, 8'h40, 8'h00, 1'b0);
		w(3);
		`CHK(rate, 2'h1)
		apb(1'b1, `RMS_ADDR, 8'h00, 8'h00, 1'b0);
		w(3);
		`CHK(rate, 2'h0)
		apb(1'b1, `RMS_ADDR, 8'hFF, 8'h00, 1'b0);
		w(3);
		`CHK(rate, 2'h2)
		`CHK(coax, 1'b1)
		strb <= 4'hE;
		apb(1'b1, `RMS_ADDR, 8'h00, 8'h00, 1'b0);
		strb <= 4'hF;
		apb(1'b0, `RMS_ADDR, 8'h00, 8'h7C, 1'b0);
		apb(1'b1, 12'h094, 8'hFF, 8'h00, 1'b1);
		apb(1'b0, 12'h094, 8'h00, 8'h00, 1'b1);
		$display("rate test done");
	endtask
	task automatic t_audio();
		aux_valid <= 1'b1;
		aux_code <= 2'h2;
		w(1);
		aux_valid <= 1'b0;
		w(3);
		`CHK(aud, 2'h2)
		apb(1'b1, `RMS_ADDR, 8'h10, 8'h00, 1'b0);
		aux_valid <= 1'b1;
		aux_code <= 2'h1;
		w(1);
		aux_valid <= 1'b0;
		w(3);
		`CHK(aud, 2'h2)
		`CHK(aud_auto, 1'b0)
		$display("audio test done");
	endtask
	task automatic t_selftest();
		auto_ack <= 1'b0;
		apb(1'b1, `ST_ADDR, 8'h45, 8'h00, 1'b0);
		w(2);
		`CHK(req, 1'b1)
		`CHK(waddr, 8'h14)
		`CHK(wdata, 2'h2)
		t0 = tx;
		w(1);
		`CHK(tx ^ t0, 1'b1)
		w(6);
		`CHK(src, 2'h2)
		`CHK(st_act, 1'b1)
		apb(1'b1, `ST_ADDR, 8'h04, 8'h00, 1'b0);
		w(3);
		`CHK(st_act, 1'b0)
		`CHK(tx, 1'b0)
		auto_ack <= 1'b1;
		pin_cfg <= 3'h7;
		apb(1'b1, `ST_ADDR, 8'h88, 8'h00, 1'b0);
		w(6);
		`CHK(src, 2'h3)
		st_data <= 1'b1;
		w(2);
		`CHK(tx, 1'b1)
		st_data <= 1'b0;
		w(2);
		`CHK(tx, 1'b0)
		apb(1'b1, `ST_ADDR, 8'h08, 8'h00, 1'b0);
		w(3);
		`CHK(tx, 1'b0)
		pin_cfg <= 3'h0;
		w(3);
		`CHK(st_act, 1'b0)
		$display("selftest test done");
	endtask
	task automatic t_osc();
		logic [5:0] tab [4];
		tab = '{`OSC_50, `OSC_25, `OSC_10, `OSC_25};
		auto_clock_en <= 1'b1;
		for (int f = 0; f < 4; f++)
		begin
			apb(1'b1, `ST_ADDR, 8'h08 | 8'(f << 4), 8'h00, 1'b0);
			w(3);
			`CHK(mhz, tab[f])
			`CHK(freq, 2'(f))
		end
		auto_clock_en <= 1'b0;
		w(3);
		`CHK(mhz, 6'h00)
		$display("osc test done");
	endtask
	task automatic t_restrap();
		rst <= 1'b1;
		strap <= 3'h2;
		w(2);
		rst <= 1'b0;
		w(3);
		`CHK(coax, 1'b1)
		`CHK(rptr, 1'b0)
		`CHK(rate, 2'h0)
		`CHK(aud_auto, 1'b1)
		apb(1'b0, `RMS_ADDR, 8'h00, 8'h28, 1'b0);
		apb(1'b0, `ST_ADDR, 8'h00, `ST_RST, 1'b0);
		$display("restrap test done");
	endtask
	initial
	begin
		w(20000);
		err_total++;
		conclude();
	end
	initial
	begin
		rst = 1'b1;
		{psel, penable, pwrite, auto_clock_en, aux_valid, st_data, auto_ack} = 7'h00;
		paddr = 12'h000;
		strb = 4'hF;
		pwdata = 32'h00000000;
		strap = 3'h5;
		pin_cfg = 3'h0;
		aux_code = 2'h0;
		w(5);
		rst <= 1'b0;
		w(3);
		t_reset();
		t_rate();
		t_audio();
		t_selftest();
		t_osc();
		t_restrap();
		conclude();
	end
endmodule
